// *** verilog/svm_pkg.sv ***
// package for the supply voltage monitor: offsets, fields, timing, types
package svm_pkg;
  // register index as printed; each register takes one aligned word at four times it
  localparam logic [31:0] SVM_CTRL_STATUS_IDX = 32'h0000_ff12;
  localparam logic [31:0] SVM_CTRL_STATUS_ADDR = {SVM_CTRL_STATUS_IDX[29:0], 2'b00};
  localparam int SVM_AUTO_BIT = 5;
  localparam int SVM_CONT_BIT = 4;
  localparam int SVM_LEVEL_LSB = 0;
  localparam int SVM_LEVEL_W = 4;
  localparam int SVM_CLK_HZ = 100000000;
  localparam int SVM_TICK_HZ = 2048;
  localparam int SVM_TICK_DIV = SVM_CLK_HZ / SVM_TICK_HZ;
  localparam int SVM_SAMPLE_TICKS = 16;
  localparam int SVM_AUTO_PERIOD_S = 4;
  localparam int SVM_AUTO_TICKS = SVM_AUTO_PERIOD_S * SVM_TICK_HZ;
  localparam logic [7:0] SVM_CTRL_RESET = 8'h00;
  localparam logic [31:0] SVM_UNMAPPED_DATA = 32'h0000_0000;

  typedef enum logic [2:0] {
    SVM_OFF   = 3'b001,
    SVM_RUN   = 3'b010,
    SVM_WAIT  = 3'b100
  } svm_state_t;

  typedef struct packed {
    logic        auto_sample_ctrl;
    logic        continuous_sample_ctrl;
  } svm_ctrl_t;
endpackage

// *** verilog/svm_supply_voltage_monitor.sv ***
// supply voltage monitor sampling control with an apb register slave
`timescale 1ns/1ps
// Notes on behaviour
// - continuous bit set: sample repeatedly, one full sampling each 7.8 ms
// - each sampling starts on a 2048 Hz tick and lasts 16 ticks
// - continuous samples follow back to back; result latched after each
// - clearing continuous finishes current sampling; bit reads one until off
// - continuous zero, auto one: one sampling every 4 s
// - auto sampling takes 7.8 ms; result changes once per 4 s
// - clearing auto mid-sampling still completes that sampling
// - in auto mode continuous bit reads one only while sampling
// - continuous bit reads busy status
// - after reset hardware samples once; busy reads one until done
// - level field has no reset value; first sampling sets it
// - level is plain 4-bit binary, held until next sampling
// - both control bits clear at reset and sleep entry
// - sleep during sampling delays oscillator stop until done, bits cleared
// - auto bit reads back last written or cleared value
// - byte layout: auto D5, continuous D4, level D3..D0
// - continuous one overrides auto; both zero keeps circuit off
module svm_supply_voltage_monitor
  import svm_pkg::*;
#(
  parameter int TICK_DIV = SVM_TICK_DIV,
  parameter int AUTO_TICKS = SVM_AUTO_TICKS
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        sleep_instruction_i,
  input  wire logic [3:0]  converter_result_i,
  output logic             converter_on_o,
  output logic             osc_stop_ok_o,
  output logic             tick_o
);
  // synchronisers for the analog result and sleep request
  logic [3:0] res_s1_reg, res_s2_reg;
  logic       slp_s1_reg, slp_s2_reg, slp_d_reg;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      res_s1_reg <= 4'h0;
      res_s2_reg <= 4'h0;
      slp_s1_reg <= 1'b0;
      slp_s2_reg <= 1'b0;
      slp_d_reg  <= 1'b0;
    end else begin
      res_s1_reg <= converter_result_i;
      res_s2_reg <= res_s1_reg;
      slp_s1_reg <= sleep_instruction_i;
      slp_s2_reg <= slp_s1_reg;
      slp_d_reg  <= slp_s2_reg;
    end
  end
  wire sleep_entry = slp_s2_reg & ~slp_d_reg;

  // 2048 Hz tick divider
  logic [31:0] div_reg;
  wire         tick = (div_reg == 32'(TICK_DIV - 1));
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) div_reg <= 32'h0;
    else       div_reg <= tick ? 32'h0 : div_reg + 32'h1;
  end

  // apb decode
  // the status byte sits in the low lane of its own word
  wire sel_ctrl = (paddr_i == SVM_CTRL_STATUS_ADDR);
  wire wr_acc   = psel_i & penable_i & pwrite_i & pready_o;
  wire wr_ctrl  = wr_acc & sel_ctrl & pstrb_i[0];
  wire [7:0] wbyte = pwdata_i[7:0];

  // control bits, state and counters
  svm_ctrl_t  ctrl_reg, ctrl_next;
  svm_state_t state_reg, state_next;
  logic [4:0]  smp_cnt_reg;
  logic [31:0] auto_cnt_reg;
  logic [3:0]  level_reg;
  logic        first_reg;
  wire auto_due  = (auto_cnt_reg == 32'(AUTO_TICKS - 1)) & tick;
  wire smp_done  = (state_reg == SVM_RUN) & tick & (smp_cnt_reg == 5'(SVM_SAMPLE_TICKS - 1));
  wire start_ok  = tick & (ctrl_next.continuous_sample_ctrl |
                           (ctrl_next.auto_sample_ctrl & auto_due));
  wire busy      = (state_reg != SVM_OFF);

  // software writes, hardware clears on sleep entry
  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next.auto_sample_ctrl       = wbyte[SVM_AUTO_BIT];
      ctrl_next.continuous_sample_ctrl = wbyte[SVM_CONT_BIT];
    end
    if (sleep_entry) ctrl_next = '0;
  end

  // sampling sequencer
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SVM_OFF:  if (start_ok) state_next = SVM_RUN;
      SVM_RUN:  if (smp_done) state_next = start_ok ? SVM_RUN : SVM_OFF;
      SVM_WAIT: if (tick) state_next = SVM_RUN; // first sampling waits for a tick
      default:  state_next = SVM_OFF;
    endcase
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_reg     <= svm_ctrl_t'(2'b00);
      state_reg    <= SVM_WAIT; // first hardware sampling
      smp_cnt_reg  <= 5'h0;
      auto_cnt_reg <= 32'h0;
      first_reg    <= 1'b1;
    end else begin
      ctrl_reg  <= ctrl_next;
      state_reg <= state_next;
      // counts ticks after the start tick, so a sampling spans exactly 16 ticks
      if (tick && state_reg == SVM_RUN)
        smp_cnt_reg <= smp_done ? 5'h0 : smp_cnt_reg + 5'h1;
      if (smp_done) first_reg <= 1'b0;
      if (!ctrl_reg.auto_sample_ctrl) auto_cnt_reg <= 32'h0;
      else if (tick) auto_cnt_reg <= auto_due ? 32'h0 : auto_cnt_reg + 32'h1;
    end
  end

  // result latch: all bits at once, no reset value
  always_ff @(posedge mclk_i) begin
    if (smp_done) level_reg <= res_s2_reg;
  end

  // continuous bit readback is the busy status
  // a pending continuous request reads busy before its start tick arrives
  wire       cont_rd = busy | ctrl_reg.continuous_sample_ctrl;
  wire [7:0] rbyte = {2'b00, ctrl_reg.auto_sample_ctrl, cont_rd, level_reg};

  // apb answer registers
  wire rd_setup = psel_i & ~penable_i & ~pwrite_i;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o       <= SVM_UNMAPPED_DATA;
      pready_o       <= 1'b0;
      pslverr_o      <= 1'b0;
      converter_on_o <= 1'b0;
      osc_stop_ok_o  <= 1'b0;
      tick_o         <= 1'b0;
    end else begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~sel_ctrl;
      if (rd_setup)
        prdata_o <= sel_ctrl ? {24'h00_0000, rbyte} : SVM_UNMAPPED_DATA;
      converter_on_o <= (state_next != SVM_OFF);
      osc_stop_ok_o  <= slp_s2_reg & (state_next == SVM_OFF);
      tick_o         <= tick;
    end
  end

  // assertions
  property p_busy_off;
    @(posedge mclk_i) disable iff (rst_i)
      (state_reg == SVM_OFF) && !ctrl_reg.continuous_sample_ctrl |-> !rbyte[SVM_CONT_BIT];
  endproperty
  a_busy_off: assert property (p_busy_off) else $error("busy bit high while off");
  property p_busy_read_q;
    @(posedge mclk_i) disable iff (rst_i) busy |-> rbyte[SVM_CONT_BIT];
  endproperty
  a_busy_read: assert property (p_busy_read_q) else $error("busy bit low while busy");
  property p_sleep_clear;
    @(posedge mclk_i) disable iff (rst_i) sleep_entry |=> (ctrl_reg == '0);
  endproperty
  a_sleep_clear: assert property (p_sleep_clear) else $error("sleep did not clear");
  property p_level_hold;
    @(posedge mclk_i) disable iff (rst_i) !$past(smp_done) && !first_reg |-> $stable(level_reg);
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("level changed");
  property p_off_stays;
    @(posedge mclk_i) disable iff (rst_i)
      (state_reg == SVM_OFF) && (ctrl_reg == '0) && !wr_ctrl |=> (state_reg == SVM_OFF);
  endproperty
  a_off_stays: assert property (p_off_stays) else $error("started while off");
  property p_start_tick;
    @(posedge mclk_i) disable iff (rst_i)
      (state_reg == SVM_OFF) && (state_next == SVM_RUN) |-> tick;
  endproperty
  a_start_tick: assert property (p_start_tick) else $error("start not aligned");
  property p_finish;
    @(posedge mclk_i) disable iff (rst_i) busy && tick && smp_cnt_reg < 5'd15 |=> busy;
  endproperty
  a_finish: assert property (p_finish) else $error("sampling cut short");
  property p_cont_run;
    @(posedge mclk_i) disable iff (rst_i)
      smp_done && ctrl_reg.continuous_sample_ctrl && !wr_ctrl && !sleep_entry |=> busy;
  endproperty
  a_cont_run: assert property (p_cont_run) else $error("gap in continuous");
  property p_auto_wr;
    @(posedge mclk_i) disable iff (rst_i)
      wr_ctrl && !sleep_entry |=> ctrl_reg.auto_sample_ctrl == $past(wbyte[SVM_AUTO_BIT]);
  endproperty
  a_auto_wr: assert property (p_auto_wr) else $error("auto bit not stored");
  c_done: cover property (@(posedge mclk_i) disable iff (rst_i) smp_done);
  c_sleep_busy: cover property (@(posedge mclk_i) disable iff (rst_i) sleep_entry && busy);
  c_auto: cover property (@(posedge mclk_i) disable iff (rst_i) auto_due);
  c_back_to_back: cover property (@(posedge mclk_i) disable iff (rst_i)
    smp_done && (state_next == SVM_RUN));

  // first sampling after reset reads busy until it concludes
  property p_first_busy;
    @(posedge mclk_i) disable iff (rst_i) first_reg |-> rbyte[SVM_CONT_BIT];
  endproperty
  a_first_busy: assert property (p_first_busy) else $error("first sampling not busy");

  // the oscillator stop stays held while the circuit still runs
  property p_stop_wait;
    @(posedge mclk_i) disable iff (rst_i) (state_next != SVM_OFF) |=> !osc_stop_ok_o;
  endproperty
  a_stop_wait: assert property (p_stop_wait) else $error("stop allowed while busy");

  // all four level bits take the synchronised result together
  property p_level_load;
    @(posedge mclk_i) disable iff (rst_i) smp_done |=> (level_reg == $past(res_s2_reg));
  endproperty
  a_level_load: assert property (p_level_load) else $error("level not loaded");

  // read data carries the status byte in the low lane, upper bits zero
  property p_read_layout;
    @(posedge mclk_i) disable iff (rst_i)
      rd_setup && sel_ctrl |=> (prdata_o == {24'h00_0000, $past(rbyte)});
  endproperty
  a_read_layout: assert property (p_read_layout) else $error("read data misplaced");

  // a pending continuous request starts on the next tick
  property p_cont_start;
    @(posedge mclk_i) disable iff (rst_i)
      (state_reg == SVM_OFF) && ctrl_reg.continuous_sample_ctrl && tick
      && !wr_ctrl && !sleep_entry |=> busy;
  endproperty
  a_cont_start: assert property (p_cont_start) else $error("continuous did not start");

  // between auto samplings the continuous bit reads zero
  property p_auto_idle;
    @(posedge mclk_i) disable iff (rst_i)
      !busy && !ctrl_reg.continuous_sample_ctrl |-> !rbyte[SVM_CONT_BIT];
  endproperty
  a_auto_idle: assert property (p_auto_idle) else $error("busy read between samplings");

  // every setup cycle gets its answer in the access cycle
  property p_ready;
    @(posedge mclk_i) disable iff (rst_i) psel_i && !penable_i |=> pready_o;
  endproperty
  a_ready: assert property (p_ready) else $error("no ready in access cycle");

  // unmapped addresses answer with an error
  property p_unmapped;
    @(posedge mclk_i) disable iff (rst_i) psel_i && !penable_i && !sel_ctrl |=> pslverr_o;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error for unmapped address");
endmodule

// *** verification/test_svm_supply_voltage_monitor.sv ***
// self-checking bench for the supply voltage monitor
`timescale 1ns/1ps
module test_svm_supply_voltage_monitor
  import svm_pkg::*;
();
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic        sleep_i = 1'b0;
  logic [31:0] paddr_i = 32'h0;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0]  result_i = 4'ha;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        conv_on_o;
  logic        stop_ok_o;
  int          fail_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic        er;
  logic [7:0]  b;
  logic [3:0]  row_in [4] = '{4'h0, 4'hf, 4'h6, 4'h9};
  logic [7:0]  row_out [4] = '{8'h00, 8'h0f, 8'h06, 8'h09};

  // short tick divider and auto period keep the run brief
  svm_supply_voltage_monitor #(.TICK_DIV(4), .AUTO_TICKS(40)) i_dut (
    .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(4'hf),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .sleep_instruction_i(sleep_i), .converter_result_i(result_i),
    .converter_on_o(conv_on_o), .osc_stop_ok_o(stop_ok_o), .tick_o());

  // 100 MHz clock
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  // hang guard
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [32:0] g, input logic [32:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // one apb transfer: setup, then access until pready is sampled high
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rdb();
    apb(1'b0, SVM_CTRL_STATUS_ADDR, 32'h0);
    b = rd[7:0];
  endtask

  task automatic wrb(input logic [7:0] v);
    apb(1'b1, SVM_CTRL_STATUS_ADDR, {24'h00_0000, v});
  endtask

  // poll the status byte until busy reaches the wanted level
  task automatic wait_busy(input logic lvl);
    do begin
      rdb();
    end while (b[4] !== lvl);
  endtask

  // main sequence
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_i <= 1'b0;
    rdb();
    chk(b[5:4], 2'b01);
    wait_busy(1'b0);
    chk(b, 8'h0a);
    for (int i = 0; i < 4; i++) begin
      result_i <= row_in[i];
      wrb(8'h10);
      while (conv_on_o !== 1'b1) @(posedge mclk_i);
      wrb(8'h00);
      rdb();
      chk(b[4], 1'b1);
      wait_busy(1'b0);
      chk(b, row_out[i]);
    end
    result_i <= 4'h5;
    wrb(8'h20);
    rdb();
    chk(b[5], 1'b1);
    wait_busy(1'b1);
    chk(b[4], 1'b1);
    wait_busy(1'b0);
    chk(b, 8'h25);
    wait_busy(1'b1);
    wrb(8'h00);
    chk(conv_on_o, 1'b1);
    wait_busy(1'b0);
    chk({conv_on_o, b}, 9'h005);
    wrb(8'h30);
    rdb();
    chk(b[5:4], 2'b11);
    sleep_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk({conv_on_o, stop_ok_o}, 2'b10);
    while (stop_ok_o !== 1'b1) @(posedge mclk_i);
    chk({conv_on_o, stop_ok_o}, 2'b01);
    rdb();
    chk(b[5:4], 2'b00);
    sleep_i <= 1'b0;
    apb(1'b0, 32'h0, 32'h0);
    chk({er, rd}, 33'h1_0000_0000);
    rst_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    rdb();
    chk(b[5:4], 2'b01);
    wrap_up();
  end
endmodule
